// ---- core/sync_gen_defines.svh ----
`ifndef SYNC_GEN_DEFINES_SVH
`define SYNC_GEN_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_ACT_STATUS 6'h01
`define IDX_POL_STATUS 6'h02
`define IDX_GREEN_CFG 6'h04
`define IDX_INPUT_CFG 6'h05
`define IDX_PPL_A 6'h0E
`define IDX_PPL_B 6'h0F
`define IDX_PHASE 6'h10
`define IDX_POWER 6'h1B

// reset values
`define RST_GREEN_CFG 8'h00
`define RST_INPUT_CFG 8'h00
`define RST_PPL_A 8'h32
`define RST_PPL_B 8'h00
`define RST_PHASE 8'h00
`define RST_POWER 8'h00

// field positions
`define INCFG_CHAN_BIT 0
`define INCFG_SRC_LSB 3
`define INCFG_SRC_MSB 4
`define GREEN_LPF_BIT 4
`define POWER_DOWN_BIT 0
`define PHASE_MSB 5

// status register bit positions
`define ST_TRILEVEL_BIT 6
`define ST_COMPOSITE_BIT 7

// detector run lengths; pixel index that updates the aligned frame sync
`define SYNC_RUN 2
`define GREEN_RUN 64
`define TRI_RUN 1
`define FRAME_PIXEL 12'd7

// timing
`define REF_CLK_PERIOD_NS 100
`define GLITCH_HOLD_NS 100
`define GLITCH_HOLD_CYC ((`GLITCH_HOLD_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define ACT_TIMEOUT_MS 25
`define ACT_TIMEOUT_CYC (`ACT_TIMEOUT_MS * 1000000 / `REF_CLK_PERIOD_NS)

`endif

// ---- core/sync_gen_pkg.sv ----
package sync_gen_pkg;
	typedef enum logic [1:0] {
		SRC_SEPARATE,
		SRC_COMPOSITE_HSYNC,
		SRC_COMPOSITE_GREEN,
		SRC_RESERVED
	} line_src_e;
	typedef logic [19:0] cyc_t;
	typedef logic [15:0] period_t;
	typedef logic [11:0] ppl_t;
endpackage

// ---- core/sync_glitch_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync_glitch_filter #(
	parameter int HOLD = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic raw,
	output logic clean
);
	logic [3:0] hold_r;

	// after an accepted edge the input is not looked at for HOLD cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clean <= 1'b0;
			hold_r <= 4'h0;
		end else if (hold_r != 4'h0) begin
			hold_r <= hold_r - 4'h1;
		end else if (raw != clean) begin
			clean <= raw;
			hold_r <= 4'(HOLD);
		end
	end
endmodule
`default_nettype wire

// ---- core/sync_activity_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync_activity_detect #(
	parameter int RUN = 2,
	parameter int TIMEOUT = 250000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic level,
	output logic active,
	output logic pol_high
);
	sync_gen_pkg::cyc_t per_r;
	sync_gen_pkg::cyc_t high_r;
	sync_gen_pkg::cyc_t last_per_r;
	sync_gen_pkg::cyc_t last_high_r;
	logic level_d;
	logic rise;
	logic match;
	logic timed_out;
	logic [6:0] run_r;
	logic [6:0] run_nxt;

	assign rise = level & ~level_d;
	// one cycle of slack: edges land on a 100 ns grid
	assign match = ({1'b0, per_r} <= {1'b0, last_per_r} + 21'd1) &&
		({1'b0, last_per_r} <= {1'b0, per_r} + 21'd1) &&
		({1'b0, high_r} <= {1'b0, last_high_r} + 21'd1) &&
		({1'b0, last_high_r} <= {1'b0, high_r} + 21'd1);
	assign timed_out = per_r >= sync_gen_pkg::cyc_t'(TIMEOUT);

	// period and high time since the last rising edge, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_d <= 1'b0;
			per_r <= '0;
			high_r <= '0;
		end else begin
			level_d <= level;
			if (rise) begin
				per_r <= 20'd1;
				high_r <= 20'd1;
			end else begin
				if (per_r != '1)
					per_r <= per_r + 20'd1;
				if (level && high_r != '1)
					high_r <= high_r + 20'd1;
			end
		end
	end

	// run of consecutive pulses with equal period and duty; an edge wins
	// over a timeout in the same cycle
	always_comb begin
		run_nxt = run_r;
		if (rise) begin
			if (!match)
				run_nxt = 7'd1;
			else if (run_r != 7'h7F)
				run_nxt = run_r + 7'd1;
		end else if (timed_out) begin
			run_nxt = 7'd0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_r <= 7'd0;
			active <= 1'b0;
			last_per_r <= '0;
			last_high_r <= '0;
			pol_high <= 1'b0;
		end else begin
			run_r <= run_nxt;
			active <= run_nxt >= 7'(RUN);
			if (rise) begin
				last_per_r <= per_r;
				last_high_r <= high_r;
			end
			// short high part means active high; only a steady pulse
			// updates it, so a broad vertical pulse cannot flip it
			if (rise && match)
				pol_high <= ({high_r, 1'b0} < {1'b0, per_r});
		end
	end
endmodule
`default_nettype wire

// ---- core/video_sync_detect_clockgen.sv ----
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sync_gen_defines.svh"
module video_sync_detect_clockgen #(
	parameter int ACT_TIMEOUT = `ACT_TIMEOUT_CYC
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [1:0] HSYNC_IN,
	input wire logic [1:0] VSYNC_IN,
	input wire logic [1:0] GREEN_SYNC_INPUT,
	input wire logic [1:0] TRILEVEL_IN,
	output logic RAW_LINE_SYNC_OUT,
	output logic RAW_FRAME_SYNC_OUT,
	output logic OUTPUT_DATA_CLOCK_EN,
	output logic SAMPLE_PHASE_STROBE,
	output logic ALIGNED_LINE_SYNC_OUTPUT,
	output logic ALIGNED_FRAME_SYNC_OUTPUT,
	output logic [7:0] GREEN_SLICER_CFG,
	output logic POWERED_DOWN
);
	logic [7:0] green_cfg_r;
	logic [7:0] input_cfg_r;
	logic [7:0] ppl_a_r;
	logic [7:0] ppl_b_r;
	logic [7:0] phase_r;
	logic [7:0] power_r;
	logic [31:0] prdata_r;
	logic [7:0] rd_val;
	logic idx_hit;
	logic [5:0] idx;
	logic setup_rd;
	logic access_wr;

	logic [1:0] hs_clean;
	logic [1:0] green_d_r;
	logic [1:0] green_f_r;
	logic [7:0] det_in;
	logic [7:0] det_act;
	logic [7:0] det_pol;
	logic [7:0] act_status;
	logic [7:0] pol_status;

	sync_gen_pkg::line_src_e src;
	logic ch;
	logic composite_src;
	logic line_lvl;
	logic line_pol;
	logic line_act;
	logic line_act_d_r;
	logic line_start;
	logic frame_act;
	sync_gen_pkg::period_t lp_cnt_r;
	sync_gen_pkg::period_t line_period_r;
	sync_gen_pkg::period_t act_len_r;
	logic vsep_r;
	logic vsep_d_r;
	logic vsep_rise;
	logic vsep_armed_r;
	logic composite_r;
	sync_gen_pkg::cyc_t vsep_gap_r;

	sync_gen_pkg::ppl_t ppl;
	logic pd;
	logic nco_run;
	sync_gen_pkg::period_t acc_r;
	logic [16:0] acc_sum;
	logic [21:0] phase_prod;
	sync_gen_pkg::period_t phase_off;
	sync_gen_pkg::ppl_t pix_cnt_r;
	sync_gen_pkg::ppl_t pix_nxt;
	logic pix_tick;
	logic sampled_r;
	logic tick_r;
	logic sample_r;
	logic aligned_ls_r;
	logic aligned_fs_r;

	// APB decode: aligned words only, zero wait states
	assign idx = PADDR[7:2];
	assign idx_hit = (PADDR[1:0] == 2'b00) &&
		(idx == `IDX_ACT_STATUS || idx == `IDX_POL_STATUS ||
		idx == `IDX_GREEN_CFG || idx == `IDX_INPUT_CFG ||
		idx == `IDX_PPL_A || idx == `IDX_PPL_B ||
		idx == `IDX_PHASE || idx == `IDX_POWER);
	assign setup_rd = PSEL && !PENABLE && !PWRITE;
	assign access_wr = PSEL && PENABLE && PWRITE && idx_hit;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !idx_hit;
	assign PRDATA = prdata_r;

	always_comb begin
		rd_val = 8'h00;
		if (PADDR[1:0] == 2'b00) begin
			unique case (idx)
				`IDX_ACT_STATUS: rd_val = act_status;
				`IDX_POL_STATUS: rd_val = pol_status;
				`IDX_GREEN_CFG: rd_val = green_cfg_r;
				`IDX_INPUT_CFG: rd_val = input_cfg_r;
				`IDX_PPL_A: rd_val = ppl_a_r;
				`IDX_PPL_B: rd_val = ppl_b_r;
				`IDX_PHASE: rd_val = phase_r;
				`IDX_POWER: rd_val = power_r;
				default: rd_val = 8'h00;
			endcase
		end
	end

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			prdata_r <= 32'h0000_0000;
		else if (setup_rd)
			prdata_r <= {24'h00_0000, rd_val};
	end

	// writable registers; status indices have no write path at all
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			green_cfg_r <= `RST_GREEN_CFG;
			input_cfg_r <= `RST_INPUT_CFG;
			ppl_a_r <= `RST_PPL_A;
			ppl_b_r <= `RST_PPL_B;
			phase_r <= `RST_PHASE;
			power_r <= `RST_POWER;
		end else if (access_wr) begin
			unique case (idx)
				`IDX_GREEN_CFG: green_cfg_r <= PWDATA[7:0];
				`IDX_INPUT_CFG: input_cfg_r <= PWDATA[7:0];
				`IDX_PPL_A: ppl_a_r <= PWDATA[7:0];
				`IDX_PPL_B: ppl_b_r <= PWDATA[7:0];
				`IDX_PHASE: phase_r <= PWDATA[7:0];
				`IDX_POWER: power_r <= PWDATA[7:0];
				default: ;
			endcase
		end
	end

	assign GREEN_SLICER_CFG = green_cfg_r;
	assign pd = power_r[`POWER_DOWN_BIT];
	assign POWERED_DOWN = pd;
	assign ppl = {ppl_a_r, ppl_b_r[7:4]};

	// glitch filter on each HSYNC_IN line sync input; green has its own low-pass
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_hs
			sync_glitch_filter #(
				.HOLD(`GLITCH_HOLD_CYC)
			) u_filt (
				.clk(REF_CLK),
				.rst(RST),
				.raw(HSYNC_IN[g]),
				.clean(hs_clean[g])
			);
		end
	endgenerate

	// green low-pass: a level must stand two samples before it counts,
	// which rejects single-sample spikes from video peaking
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			green_d_r <= 2'b00;
			green_f_r <= 2'b00;
		end else begin
			green_d_r <= GREEN_SYNC_INPUT;
			for (int i = 0; i < 2; i++) begin
				if (!green_cfg_r[`GREEN_LPF_BIT] ||
					GREEN_SYNC_INPUT[i] == green_d_r[i])
					green_f_r[i] <= GREEN_SYNC_INPUT[i];
			end
		end
	end

	// eight detectors; none is gated by power-down
	assign det_in = {TRILEVEL_IN, green_f_r, VSYNC_IN, hs_clean};
	generate
		for (g = 0; g < 8; g++) begin : gen_det
			localparam int RUN = (g < 4) ? `SYNC_RUN :
				(g < 6) ? `GREEN_RUN : `TRI_RUN;
			sync_activity_detect #(
				.RUN(RUN),
				.TIMEOUT(ACT_TIMEOUT)
			) u_det (
				.clk(REF_CLK),
				.rst(RST),
				.level(det_in[g]),
				.active(det_act[g]),
				.pol_high(det_pol[g])
			);
		end
	endgenerate

	assign ch = input_cfg_r[`INCFG_CHAN_BIT];
	assign src = sync_gen_pkg::line_src_e'(
		input_cfg_r[`INCFG_SRC_MSB:`INCFG_SRC_LSB]);
	assign composite_src = (src == sync_gen_pkg::SRC_COMPOSITE_HSYNC) ||
		(src == sync_gen_pkg::SRC_COMPOSITE_GREEN);
	assign act_status = {composite_r, det_act[6 + 32'(ch)], det_act[5:0]};
	assign pol_status = {2'b00, det_pol[5:0]};

	// raw outputs: muxes of the pins, except the composite frame sync, which comes from the vsep_r flop
	always_comb begin
		if (src == sync_gen_pkg::SRC_COMPOSITE_GREEN)
			RAW_LINE_SYNC_OUT = GREEN_SYNC_INPUT[ch];
		else
			RAW_LINE_SYNC_OUT = HSYNC_IN[ch];
		if (composite_src)
			RAW_FRAME_SYNC_OUT = vsep_r;
		else
			RAW_FRAME_SYNC_OUT = VSYNC_IN[ch];
	end

	// selected line sync, turned to an active-high pulse
	always_comb begin
		if (src == sync_gen_pkg::SRC_COMPOSITE_GREEN) begin
			line_lvl = green_f_r[ch];
			line_pol = 1'b0; // green sync tips are always low
		end else begin
			line_lvl = hs_clean[ch];
			line_pol = det_pol[32'(ch)];
		end
		line_act = line_pol ? line_lvl : ~line_lvl;
		if (composite_src)
			frame_act = vsep_r;
		else
			frame_act = det_pol[2 + 32'(ch)] ? VSYNC_IN[ch] : ~VSYNC_IN[ch];
	end
	assign line_start = line_act && !line_act_d_r;
	assign vsep_rise = vsep_r && !vsep_d_r;

	// line period and composite separator; active in power-down
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			line_act_d_r <= 1'b0;
			lp_cnt_r <= '0;
			line_period_r <= '0;
			act_len_r <= '0;
			vsep_r <= 1'b0;
			vsep_d_r <= 1'b0;
		end else begin
			line_act_d_r <= line_act;
			vsep_d_r <= vsep_r;
			if (line_start) begin
				lp_cnt_r <= 16'd1;
				// broad pulses would corrupt the period, so hold it
				if (!vsep_r)
					line_period_r <= lp_cnt_r;
			end else if (lp_cnt_r != '1) begin
				lp_cnt_r <= lp_cnt_r + 16'd1;
			end
			if (line_act) begin
				if (act_len_r != '1)
					act_len_r <= act_len_r + 16'd1;
				// active past half a line: a broad vertical pulse
				if ({act_len_r, 1'b0} >= {1'b0, line_period_r} &&
					line_period_r != '0)
					vsep_r <= 1'b1;
			end else begin
				if (line_act_d_r && {act_len_r, 1'b0} <
					{1'b0, line_period_r})
					vsep_r <= 1'b0;
				act_len_r <= '0;
			end
		end
	end

	// composite present: two vertical pulses within the timeout;
	// a new vertical pulse wins over the timeout in the same cycle
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			vsep_armed_r <= 1'b0;
			composite_r <= 1'b0;
			vsep_gap_r <= '0;
		end else if (!composite_src) begin
			vsep_armed_r <= 1'b0;
			composite_r <= 1'b0;
			vsep_gap_r <= '0;
		end else if (vsep_rise) begin
			vsep_gap_r <= '0;
			vsep_armed_r <= 1'b1;
			if (vsep_armed_r)
				composite_r <= 1'b1;
		end else if (vsep_gap_r >= sync_gen_pkg::cyc_t'(ACT_TIMEOUT)) begin
			vsep_armed_r <= 1'b0;
			composite_r <= 1'b0;
		end else begin
			vsep_gap_r <= vsep_gap_r + 20'd1;
		end
	end

	// pixel NCO: adds the pixel count each cycle and wraps at the line
	// period, giving ppl ticks per line; limited to ppl below the period
	assign nco_run = !pd && ppl != '0 && line_period_r != '0;
	assign acc_sum = {1'b0, acc_r} + {5'h00, ppl};
	assign pix_tick = nco_run && (line_start ||
		acc_sum >= {1'b0, line_period_r});
	assign pix_nxt = (line_start || pix_cnt_r + 12'd1 >= ppl) ?
		12'd0 : pix_cnt_r + 12'd1;
	assign phase_prod = line_period_r * phase_r[`PHASE_MSB:0];
	assign phase_off = phase_prod[21:6];

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			acc_r <= '0;
			pix_cnt_r <= '0;
			sampled_r <= 1'b0;
			sample_r <= 1'b0;
			tick_r <= 1'b0;
		end else if (!nco_run) begin
			acc_r <= '0;
			pix_cnt_r <= '0;
			sampled_r <= 1'b0;
			sample_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= pix_tick;
			if (line_start)
				acc_r <= '0;
			else if (pix_tick)
				acc_r <= 16'(acc_sum - {1'b0, line_period_r});
			else
				acc_r <= acc_sum[15:0];
			if (pix_tick)
				pix_cnt_r <= pix_nxt;
			// at most one strobe per pixel, phase/64 of the way through it
			sample_r <= !pix_tick && !sampled_r && acc_r >= phase_off;
			if (pix_tick)
				sampled_r <= 1'b0;
			else if (acc_r >= phase_off)
				sampled_r <= 1'b1;
		end
	end

	// aligned outputs change only on pixel ticks, and clear while the NCO is stopped
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			aligned_ls_r <= 1'b0;
			aligned_fs_r <= 1'b0;
		end else if (!nco_run) begin
			aligned_ls_r <= 1'b0;
			aligned_fs_r <= 1'b0;
		end else if (pix_tick) begin
			aligned_ls_r <= pix_nxt == 12'd0;
			if (pix_nxt == `FRAME_PIXEL)
				aligned_fs_r <= frame_act;
		end
	end

	assign OUTPUT_DATA_CLOCK_EN = tick_r;
	assign SAMPLE_PHASE_STROBE = sample_r;
	assign ALIGNED_LINE_SYNC_OUTPUT = aligned_ls_r;
	assign ALIGNED_FRAME_SYNC_OUTPUT = aligned_fs_r;
endmodule
`default_nettype wire

// ---- sim/sync_detect_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync_detect_monitor (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PSLVERR,
	input wire logic [1:0] HSYNC_IN,
	input wire logic [1:0] VSYNC_IN,
	input wire logic [1:0] GREEN_SYNC_INPUT,
	input wire logic RAW_LINE_SYNC_OUT,
	input wire logic RAW_FRAME_SYNC_OUT,
	input wire logic OUTPUT_DATA_CLOCK_EN,
	input wire logic ALIGNED_LINE_SYNC_OUTPUT,
	input wire logic ALIGNED_FRAME_SYNC_OUTPUT,
	input wire logic [7:0] GREEN_SLICER_CFG,
	input wire logic POWERED_DOWN
);
	logic [7:0] incfg_r;
	logic ch;
	logic [1:0] src;
	// shadow of the source register, so the expected mux leg is known
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			incfg_r <= 8'h00;
		end else if (PSEL && PENABLE && PWRITE && PADDR == 8'h14) begin
			incfg_r <= PWDATA[7:0];
		end
	end
	assign ch = incfg_r[0];
	assign src = incfg_r[4:3];
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	sequence s_green_wr;
		PSEL && PENABLE && PWRITE && PADDR == 8'h10;
	endsequence
	sequence s_power_wr;
		PSEL && PENABLE && PWRITE && PADDR == 8'h6C;
	endsequence
	sequence s_running;
		!POWERED_DOWN [*2];
	endsequence
	property p_raw_line;
		RAW_LINE_SYNC_OUT == (src == 2'h2 ? GREEN_SYNC_INPUT[ch] : HSYNC_IN[ch]);
	endproperty
	property p_raw_frame;
		(src == 2'h0 || src == 2'h3) |-> RAW_FRAME_SYNC_OUT == VSYNC_IN[ch];
	endproperty
	property p_unmapped;
		PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR;
	endproperty
	property p_status_wr;
		PSEL && PENABLE && (PADDR == 8'h04 || PADDR == 8'h08) |-> !PSLVERR;
	endproperty
	property p_green_cfg;
		s_green_wr |=> GREEN_SLICER_CFG == $past(PWDATA[7:0]);
	endproperty
	property p_power;
		s_power_wr |=> POWERED_DOWN == $past(PWDATA[0]);
	endproperty
	property p_pd_quiet;
		POWERED_DOWN [*2] |-> !OUTPUT_DATA_CLOCK_EN;
	endproperty
	property p_line_tick;
		s_running ##0 $changed(ALIGNED_LINE_SYNC_OUTPUT) |-> OUTPUT_DATA_CLOCK_EN;
	endproperty
	property p_frame_tick;
		s_running ##0 $changed(ALIGNED_FRAME_SYNC_OUTPUT) |-> OUTPUT_DATA_CLOCK_EN;
	endproperty
	a_raw_line: assert property (p_raw_line)
		else $error("raw line sync differs from selected input");
	a_raw_frame: assert property (p_raw_frame)
		else $error("raw frame sync differs from selected input");
	a_unmapped: assert property (p_unmapped)
		else $error("no error on misaligned access");
	a_status_wr: assert property (p_status_wr)
		else $error("error on status register access");
	a_green_cfg: assert property (p_green_cfg)
		else $error("green slicer setting not applied");
	a_power: assert property (p_power)
		else $error("power bit not applied");
	a_pd_quiet: assert property (p_pd_quiet)
		else $error("pixel tick while powered down");
	a_line_tick: assert property (p_line_tick)
		else $error("line sync moved off a pixel tick");
	a_frame_tick: assert property (p_frame_tick)
		else $error("frame sync moved off a pixel tick");
endmodule
bind video_sync_detect_clockgen sync_detect_monitor i_sync_detect_monitor (
	.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
	.HSYNC_IN(HSYNC_IN), .VSYNC_IN(VSYNC_IN),
	.GREEN_SYNC_INPUT(GREEN_SYNC_INPUT),
	.RAW_LINE_SYNC_OUT(RAW_LINE_SYNC_OUT),
	.RAW_FRAME_SYNC_OUT(RAW_FRAME_SYNC_OUT),
	.OUTPUT_DATA_CLOCK_EN(OUTPUT_DATA_CLOCK_EN),
	.ALIGNED_LINE_SYNC_OUTPUT(ALIGNED_LINE_SYNC_OUTPUT),
	.ALIGNED_FRAME_SYNC_OUTPUT(ALIGNED_FRAME_SYNC_OUTPUT),
	.GREEN_SLICER_CFG(GREEN_SLICER_CFG), .POWERED_DOWN(POWERED_DOWN)
);
`default_nettype wire

// ---- sim/sync_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync_source_model #(
	parameter int LINE = 200,
	parameter int WIDTH = 20,
	parameter int VWIDTH = 150
) (
	input wire logic clk,
	input wire logic [1:0] h_en,
	input wire logic [1:0] v_en,
	input wire logic [1:0] g_en,
	input wire logic comp_en,
	output logic [1:0] hsync,
	output logic [1:0] vsync,
	output logic [1:0] green,
	output logic [1:0] trilevel
);
	int cnt = 0;
	logic [2:0] line = 3'h0;
	initial begin
		hsync = 2'h0;
		vsync = 2'h0;
		green = 2'h3;
		trilevel = 2'h0;
	end
	// line timing; eight lines make one frame
	always @(posedge clk) begin
		cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
		if (cnt == LINE - 1) begin
			line <= line + 3'h1;
		end
	end
	// slicer outputs always drive a level; an idle source sits inactive;
	// the line slicer code is taken as suited to the edge, so no ringing
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			hsync[i] <= h_en[i] && (cnt < WIDTH ||
				(comp_en && line == 3'h0 && cnt < VWIDTH)); // long pulse = vertical
			vsync[i] <= v_en[i] && line == 3'h0;
			green[i] <= !(g_en[i] && cnt < WIDTH); // low is the sync tip
			trilevel[i] <= g_en[i] && cnt >= WIDTH && cnt < WIDTH + 4;
		end
	end
endmodule
`default_nettype wire

// ---- sim/video_sync_detect_clockgen_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module video_sync_detect_clockgen_tb;
	logic REF_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
	logic PWRITE = 1'b0, PREADY, PSLVERR, comp = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic [1:0] hs, vs, gs, ts, h_en = 2'h0, v_en = 2'h0, g_en = 2'h0;
	logic rl, rf, tick, strobe, al, af, pd;
	logic [7:0] gcfg;
	int num_errors = 0, checks_done = 0, cyc = 0;
	always #50 REF_CLK = ~REF_CLK;
	// short activity timeout keeps the run brief; frames last 1600 cycles
	video_sync_detect_clockgen #(.ACT_TIMEOUT(4000)) i_video_sync_detect_clockgen (
		.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .HSYNC_IN(hs), .VSYNC_IN(vs),
		.GREEN_SYNC_INPUT(gs), .TRILEVEL_IN(ts), .RAW_LINE_SYNC_OUT(rl),
		.RAW_FRAME_SYNC_OUT(rf), .OUTPUT_DATA_CLOCK_EN(tick),
		.SAMPLE_PHASE_STROBE(strobe), .ALIGNED_LINE_SYNC_OUTPUT(al),
		.ALIGNED_FRAME_SYNC_OUTPUT(af), .GREEN_SLICER_CFG(gcfg),
		.POWERED_DOWN(pd));
	sync_source_model i_sync_source_model (.clk(REF_CLK), .h_en(h_en),
		.v_en(v_en), .g_en(g_en), .comp_en(comp), .hsync(hs), .vsync(vs),
		.green(gs), .trilevel(ts));
	task close_out;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// a hang ends the run through the normal report
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			close_out();
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task range(input int got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, lo);
			num_errors++;
		end
	endtask
	// one transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, {24'h0, d}, q, e);
		check({31'h0, e}, 32'h0);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(q & m, x);
		check({31'h0, e}, {31'h0, xe});
	endtask
	task s_registers;
		rd(8'h10, 32'hFF, 32'h00, 1'b0);
		rd(8'h14, 32'hFF, 32'h00, 1'b0);
		rd(8'h38, 32'hFF, 32'h32, 1'b0);
		rd(8'h3C, 32'hFF, 32'h00, 1'b0);
		rd(8'h40, 32'hFF, 32'h00, 1'b0);
		wr(8'h04, 8'hFF);
		rd(8'h04, 32'hFFFFFFFF, 32'h0, 1'b0);
		wr(8'h08, 8'hFF);
		rd(8'h08, 32'hFFFFFFC0, 32'h0, 1'b0);
		rd(8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1);
		rd(8'h41, 32'hFFFFFFFF, 32'h0, 1'b1);
		wr(8'h10, 8'h16);
		rd(8'h10, 32'hFF, 32'h16, 1'b0);
	endtask
	task s_separate;
		@(posedge REF_CLK);
		h_en <= 2'h1;
		v_en <= 2'h1;
		// a frame pulse cut by the enable needs a fourth edge to match
		repeat (5200) @(posedge REF_CLK);
		rd(8'h04, 32'hFF, 32'h05, 1'b0);
		rd(8'h08, 32'h05, 32'h05, 1'b0);
	endtask
	task count(input int n, output int t, output int s, output int l);
		logic p;
		t = 0;
		s = 0;
		l = 0;
		p = 1'b1;
		repeat (n) begin
			@(posedge REF_CLK);
			t += int'(tick === 1'b1);
			s += int'(strobe === 1'b1);
			l += int'(al === 1'b1 && p !== 1'b1);
			p = al;
		end
	endtask
	// rising edges of the aligned (0) or raw (1) frame sync in n cycles
	task rises(input int n, input logic which, output int k);
		logic p;
		logic v;
		k = 0;
		p = 1'b1;
		repeat (n) begin
			@(posedge REF_CLK);
			v = which ? rf : af;
			k += int'(v === 1'b1 && p !== 1'b1);
			p = v;
		end
	endtask
	task s_pixel;
		int t, s, l, k;
		wr(8'h38, 8'h02);
		wr(8'h3C, 8'h80);
		wr(8'h40, 8'h20);
		repeat (600) @(posedge REF_CLK);
		count(1000, t, s, l);
		range(t, 198, 202);
		range(s, 198, 202);
		range(l, 4, 6);
		rises(1700, 1'b0, k);
		range(k, 1, 2);
		wr(8'h6C, 8'h01);
		// the tick launched at the write edge still shows one cycle later
		repeat (2) @(posedge REF_CLK);
		count(1000, t, s, l);
		range(t, 0, 0);
		rd(8'h04, 32'h05, 32'h05, 1'b0);
		wr(8'h6C, 8'h00);
	endtask
	task s_timeout;
		@(posedge REF_CLK);
		h_en <= 2'h0;
		v_en <= 2'h0;
		repeat (4400) @(posedge REF_CLK);
		rd(8'h04, 32'hFF, 32'h00, 1'b0);
	endtask
	task s_green;
		wr(8'h14, 8'h01);
		@(posedge REF_CLK);
		g_en <= 2'h2;
		repeat (1300) @(posedge REF_CLK);
		rd(8'h04, 32'hFF, 32'h40, 1'b0);
		repeat (12400) @(posedge REF_CLK);
		rd(8'h04, 32'hFF, 32'h60, 1'b0);
		wr(8'h14, 8'h11);
	endtask
	task s_composite;
		int k;
		wr(8'h14, 8'h08);
		@(posedge REF_CLK);
		g_en <= 2'h0;
		h_en <= 2'h1;
		comp <= 1'b1;
		repeat (4000) @(posedge REF_CLK);
		rd(8'h04, 32'h80, 32'h80, 1'b0);
		rises(1700, 1'b1, k);
		range(k, 1, 2);
	endtask
	initial begin
		repeat (3) @(posedge REF_CLK);
		RST <= 1'b0;
		s_registers();
		s_separate();
		s_pixel();
		s_timeout();
		s_green();
		s_composite();
		close_out();
	end
endmodule
`default_nettype wire
